// *** hw/irq_arbiter.sv ***
// Interrupt arbiter with non-maskable edge input, level pins and
// peripheral requests, plus the exception-entry sequencer.
// Assumes an AXI4-Lite master and a CPU that strobes decode.
//
// Functional notes
// - Control bit 15 reads the live non-maskable pin; writes ignored.
// - Control bits 14..9 and 7..1 always read zero.
// - Edge select 0 detects falling, 1 rising non-maskable edges.
// - Auto mode: level pins give vector 64 plus level halved.
// - External mode: vector 0..127 read from low data pins.
// - Highest level request wins; others stay pending.
// - Ties resolved by fixed order: level pins, then lower index.
// - Forward only when level strictly above CPU mask.
// - Forwarded request taken at decode, replacing that instruction.
// - Entry pushes status and PC, then loads accepted level into mask (15 for non-maskable).
// - Handler address fetched from table, jump without delay slot.
// - Compare takes 2 states for fast sources, 5 for level pins.
// - No acceptance while an entry sequence is running.
// - Level pins filtered; sampled on every clock edge.
// - Non-maskable pending cleared right after replaced decode.
// - Peripheral assert and removal each take 2 cycles.
// - Vector address is base plus four times vector number.
`default_nettype none
module irq_arbiter
	import irq_arb_pkg::*;
#(
	parameter int         NPER    = 4,
	parameter logic [6:0] NMI_VEC = 7'h0b  // Arbitrary default
) (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_rst,
	input  wire irq_arb_pkg::axil_req_t         i_axil,
	output irq_arb_pkg::axil_rsp_t              o_axil,
	input  wire logic                           i_nmi_pin,
	input  wire logic [3:0]                     i_level_request_pins,
	input  wire logic [NPER-1:0]                i_periph_req,
	input  wire logic [NPER-1:0][3:0]           i_periph_level,
	input  wire logic [NPER-1:0][6:0]           i_periph_vec,
	input  wire logic [3:0]                     i_cpu_mask_level,
	input  wire logic [31:0]                    i_vector_base,
	input  wire logic                           i_decode,
	input  wire logic                           i_mem_ack,
	input  wire logic [31:0]                    i_mem_rdata,
	input  wire logic [7:0]                     i_low_data_pins,
	output logic                                o_irq_req,
	output logic [4:0]                          o_irq_level,
	output logic                                o_accept,
	output logic                                o_mem_req,
	output irq_arb_pkg::seq_state_t             o_mem_op,
	output logic [31:0]                         o_mem_addr,
	output logic                                o_mask_load,
	output logic [3:0]                          o_new_mask
);
	import irq_arb_pkg::*;

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------
	logic              edge_q, vmode_q, nmi_prev_q, nmi_pend_q;
	logic              nmi_edge;
	logic [NPER-1:0]   per_d;
	logic [3:0]        irl_f, irl_d;
	logic [4:0]        sel_lvl, sel_lvl_q;
	logic [6:0]        sel_vec, sel_vec_q;
	src_kind_t         sel_kind, sel_kind_q;
	logic              req_cond;
	seq_state_t        st_q;
	src_kind_t         acc_kind_q;
	logic [4:0]        acc_lvl_q;
	logic [6:0]        acc_vec_q;
	logic              acc_ext_q;
	logic [6:0]        vec_n;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ------------------------------------------------------------
	// Source conditioning
	// ------------------------------------------------------------
	req_delay #(.W(NPER), .DEPTH(FAST_STAGES)) u_per_dly (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_d       (i_periph_req),
		.o_q       (per_d)
	);

	level_filter #(.W(4), .STABLE(FILT_STABLE)) u_irl_filt (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_d       (i_level_request_pins),
		.o_q       (irl_f)
	);
	assign irl_d = irl_f;

	assign nmi_edge = edge_q ? (i_nmi_pin & ~nmi_prev_q)
	                         : (~i_nmi_pin & nmi_prev_q);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			nmi_prev_q <= 1'b0;
			nmi_pend_q <= 1'b0;
		end else begin
			nmi_prev_q <= i_nmi_pin;
			// New edge wins over the clear at acceptance
			nmi_pend_q <= nmi_edge | (nmi_pend_q & ~(o_accept &&
			              sel_kind_q == SRC_NMI));
		end
	end

	// ------------------------------------------------------------
	// Arbitration and mask compare
	// ------------------------------------------------------------
	always_comb begin
		sel_lvl  = '0;
		sel_vec  = '0;
		sel_kind = SRC_NONE;
		for (int i = NPER - 1; i >= 0; i--) begin
			if (per_d[i] && i_periph_level[i] != 4'h0 &&
			    {1'b0, i_periph_level[i]} >= sel_lvl) begin
				sel_lvl  = {1'b0, i_periph_level[i]};
				sel_vec  = i_periph_vec[i];
				sel_kind = SRC_PERIPH;
			end
		end
		if (irl_d != 4'h0 && {1'b0, irl_d} >= sel_lvl) begin
			sel_lvl  = {1'b0, irl_d};
			sel_vec  = AUTO_VEC_LO + {4'h0, irl_d[3:1]};
			sel_kind = SRC_IRL;
		end
		if (nmi_pend_q) begin
			sel_lvl  = NMI_LEVEL;
			sel_vec  = NMI_VEC;
			sel_kind = SRC_NMI;
		end
	end

	assign req_cond = sel_kind != SRC_NONE &&
	                  sel_lvl > {1'b0, i_cpu_mask_level};

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sel_lvl_q   <= '0;
			sel_vec_q   <= '0;
			sel_kind_q  <= SRC_NONE;
			o_irq_req   <= 1'b0;
			o_irq_level <= '0;
		end else begin
			sel_lvl_q   <= sel_lvl;
			sel_vec_q   <= sel_vec;
			sel_kind_q  <= sel_kind;
			o_irq_req   <= req_cond;
			o_irq_level <= sel_lvl;
		end
	end

	// Taken only between instructions and outside a sequence
	assign o_accept = i_decode && o_irq_req && st_q == S_IDLE;

	// ------------------------------------------------------------
	// Exception entry sequencer
	// ------------------------------------------------------------
	assign vec_n = (st_q == S_EXT) ? i_low_data_pins[6:0]
	                               : acc_vec_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_q        <= S_IDLE;
			acc_kind_q  <= SRC_NONE;
			acc_lvl_q   <= '0;
			acc_vec_q   <= '0;
			acc_ext_q   <= 1'b0;
			o_mem_addr  <= '0;
			o_mask_load <= 1'b0;
			o_new_mask  <= '0;
		end else begin
			o_mask_load <= 1'b0;
			case (st_q)
				S_IDLE: begin
					if (o_accept) begin
						acc_kind_q <= sel_kind_q;
						acc_lvl_q  <= sel_lvl_q;
						acc_vec_q  <= sel_vec_q;
						acc_ext_q  <= vmode_q && sel_kind_q == SRC_IRL;
						o_mem_addr <= '0;
						st_q       <= S_SR;
					end
				end
				S_SR: begin
					if (i_mem_ack) st_q <= S_PC;
				end
				S_PC: begin
					if (i_mem_ack) begin
						o_mask_load <= 1'b1;
						o_new_mask  <= acc_lvl_q[4] ? MAX_MASK
						                            : acc_lvl_q[3:0];
						if (acc_ext_q) begin
							st_q <= S_EXT;
						end else begin
							st_q       <= S_VEC;
							o_mem_addr <= i_vector_base +
							              {23'h0, vec_n, 2'b00};
						end
					end
				end
				S_EXT: begin
					if (i_mem_ack) begin
						acc_vec_q  <= vec_n;
						st_q       <= S_VEC;
						o_mem_addr <= i_vector_base +
						              {23'h0, vec_n, 2'b00};
					end
				end
				S_VEC: begin
					if (i_mem_ack) begin
						o_mem_addr <= i_mem_rdata;
						st_q       <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (i_mem_ack) st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	assign o_mem_req = st_q != S_IDLE;
	assign o_mem_op  = st_q;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic              aw_q, w_q, b_q, r_q, rd_ctrl_q;
	logic [ADDR_W-1:0] awa_q;
	logic [31:0]       wd_q, rdata_q, ctrl_rd, stat_rd;
	logic [3:0]        ws_q;
	logic [1:0]        bresp_q, rresp_q;
	logic              wr_go;

	assign wr_go   = aw_q && w_q && !b_q;
	assign ctrl_rd = {16'h0, i_nmi_pin, 6'h0, edge_q,
	                  7'h0, vmode_q};
	assign stat_rd = {13'h0, st_q, 1'b0, acc_vec_q, 1'b0,
	                  o_irq_req, nmi_pend_q, sel_lvl_q};

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			aw_q  <= 1'b0;
			awa_q <= '0;
		end else if (i_axil.awvalid && !aw_q && !b_q) begin
			aw_q  <= 1'b1;
			awa_q <= i_axil.awaddr;
		end else if (wr_go) begin
			aw_q  <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			w_q  <= 1'b0;
			wd_q <= '0;
			ws_q <= '0;
		end else if (i_axil.wvalid && !w_q && !b_q) begin
			w_q  <= 1'b1;
			wd_q <= i_axil.wdata;
			ws_q <= i_axil.wstrb;
		end else if (wr_go) begin
			w_q  <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			b_q     <= 1'b0;
			bresp_q <= RESP_OKAY;
			edge_q  <= EDGE_RST;
			vmode_q <= VMODE_RST;
		end else if (wr_go) begin
			b_q     <= 1'b1;
			bresp_q <= RESP_OKAY;
			if (awa_q == CTRL_OFS) begin
				if (ws_q[EDGE_LANE])  edge_q  <= wd_q[EDGE_BIT];
				if (ws_q[VMODE_LANE]) vmode_q <= wd_q[VMODE_BIT];
			end else if (awa_q != STAT_OFS) begin
				bresp_q <= RESP_SLVERR;
			end
		end else if (b_q && i_axil.bready) begin
			b_q     <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r_q       <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
			rd_ctrl_q <= 1'b0;
		end else if (i_axil.arvalid && !r_q) begin
			r_q       <= 1'b1;
			rd_ctrl_q <= i_axil.araddr == CTRL_OFS;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
			if (i_axil.araddr == CTRL_OFS)      rdata_q <= ctrl_rd;
			else if (i_axil.araddr == STAT_OFS) rdata_q <= stat_rd;
			else                                rresp_q <= RESP_SLVERR;
		end else if (r_q && i_axil.rready) begin
			r_q       <= 1'b0;
		end
	end

	assign o_axil = '{awready: !aw_q && !b_q, wready: !w_q && !b_q,
	                  bvalid: b_q, bresp: bresp_q, arready: !r_q,
	                  rvalid: r_q, rdata: rdata_q, rresp: rresp_q};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_nmi_read_live: assert property (
		i_axil.arvalid && !r_q && i_axil.araddr == CTRL_OFS
		|=> rdata_q[NMI_LVL_BIT] == $past(i_nmi_pin))
		else $error("level bit not live pin");
	a_ctrl_reserved: assert property (
		r_q && rd_ctrl_q |-> rdata_q[14:9] == 6'h0 &&
		rdata_q[7:1] == 7'h0)
		else $error("reserved control bits set");
	a_nmi_latency: assert property (
		nmi_edge |-> ##2 o_irq_req)
		else $error("nmi not forwarded in 2");
	a_auto_vector: assert property (
		st_q == S_VEC && acc_kind_q == SRC_IRL && !acc_ext_q
		|-> acc_vec_q == AUTO_VEC_LO + {4'h0, acc_lvl_q[3:1]})
		else $error("auto vector wrong");
	a_ext_vector: assert property (
		st_q == S_EXT && i_mem_ack
		|=> st_q == S_VEC && acc_vec_q == $past(i_low_data_pins[6:0]))
		else $error("external vector not taken");
	a_mask_compare: assert property (
		o_irq_req && !nmi_pend_q && !$past(nmi_pend_q)
		|-> $past(sel_lvl) > {1'b0, $past(i_cpu_mask_level)})
		else $error("request not above mask");
	a_accept_entry: assert property (
		o_accept |=> st_q == S_SR && acc_lvl_q == $past(sel_lvl_q))
		else $error("accept did not start entry");
	a_mask_load: assert property (
		st_q == S_PC && i_mem_ack && acc_lvl_q != NMI_LEVEL
		|=> o_mask_load && o_new_mask == acc_lvl_q[3:0])
		else $error("mask not loaded");
	a_vector_addr: assert property (
		st_q == S_VEC && $past(st_q) != S_VEC |-> o_mem_addr ==
		$past(i_vector_base) + {23'h0, acc_vec_q, 2'b00})
		else $error("vector address wrong");
	a_nmi_clear: assert property (
		o_accept && sel_kind_q == SRC_NMI && !nmi_edge
		|=> !nmi_pend_q)
		else $error("nmi pending not cleared");
	a_busy_block: assert property (
		st_q != S_IDLE |-> !o_accept)
		else $error("accept during sequence");
endmodule
`default_nettype wire

// *** hw/irq_arb_pkg.sv ***
// Constants, types and bus carriers for the interrupt arbiter.
// Assumes a single 10 MHz system clock and an AXI4-Lite master.
`default_nettype none
package irq_arb_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  STAT_OFS     = 8'h04;
	localparam int          NMI_LVL_BIT  = 15;
	localparam int          EDGE_BIT     = 8;
	localparam int          VMODE_BIT    = 0;
	localparam int          EDGE_LANE    = 1;
	localparam int          VMODE_LANE   = 0;
	localparam logic        EDGE_RST     = 1'b0;
	localparam logic        VMODE_RST    = 1'b0;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	// ------------------------------------------------------------
	// Levels, vectors, timing
	// ------------------------------------------------------------
	localparam logic [4:0]  NMI_LEVEL    = 5'h10;
	localparam logic [3:0]  MAX_MASK     = 4'hf;
	localparam logic [6:0]  AUTO_VEC_LO  = 7'h40;
	localparam int          CLK_MHZ      = 10;
	localparam int          CMP_FAST     = 2;
	localparam int          CMP_IRL      = 5;
	localparam int          FAST_STAGES  = CMP_FAST - 1;
	localparam int          FILT_STABLE  = CMP_IRL - CMP_FAST;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_SR    = 3'h1,
		S_PC    = 3'h3,
		S_EXT   = 3'h2,
		S_VEC   = 3'h6,
		S_FETCH = 3'h4
	} seq_state_t;
	typedef enum logic [1:0] {
		SRC_NONE, SRC_NMI, SRC_PERIPH, SRC_IRL
	} src_kind_t;
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;
endpackage
`default_nettype wire

// *** hw/req_delay.sv ***
// Fixed-depth delay line for request bits.
// Assumes synchronous inputs on the system clock.
`default_nettype none
module req_delay #(
	parameter int W     = 4,
	parameter int DEPTH = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] stg_q [DEPTH];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			for (int i = 0; i < DEPTH; i++) stg_q[i] <= '0;
		end else begin
			stg_q[0] <= i_d;
			for (int i = 1; i < DEPTH; i++) stg_q[i] <= stg_q[i-1];
		end
	end

	assign o_q = stg_q[DEPTH-1];
endmodule
`default_nettype wire

// *** hw/level_filter.sv ***
// Noise filter: output follows input once stable for STABLE edges.
// Assumes synchronous inputs on the system clock.
`default_nettype none
module level_filter #(
	parameter int W      = 4,
	parameter int STABLE = 3
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	localparam int CW = $clog2(STABLE) + 1;
	localparam logic [CW-1:0] LAST = CW'(STABLE - 1);
	logic [W-1:0]  smp_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			smp_q <= '0;
			cnt_q <= '0;
			o_q   <= '0;
		end else begin
			smp_q <= i_d;
			if (smp_q == o_q || smp_q != i_d) begin
				cnt_q <= '0;
			end else if (cnt_q == LAST) begin
				o_q   <= smp_q;
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/cpu_mem_model.sv ***
// CPU-side memory responder for the interrupt entry sequence.
// Assumes the arbiter's step handshake on the system clock.
`default_nettype none
module cpu_mem_model #(
	parameter logic [6:0]  EXT_VEC = 7'h55,
	parameter logic [31:0] HND_OFS = 32'h0001_0000
) (
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	input  wire logic                    i_mem_req,
	input  wire irq_arb_pkg::seq_state_t i_mem_op,
	input  wire logic [31:0]             i_mem_addr,
	output logic                         o_mem_ack,
	output logic [31:0]                  o_mem_rdata,
	output logic [7:0]                   o_low_data_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import irq_arb_pkg::*;
	logic [1:0] wait_q;
	logic       slow_q;
	// ------------------------------------------------------------
	// Step acknowledge, alternately prompt and slow
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_mem_ack <= 1'b0;
			wait_q    <= 2'h0;
			slow_q    <= 1'b0;
		end else if (o_mem_ack) begin
			o_mem_ack <= 1'b0;
			wait_q    <= 2'h0;
			slow_q    <= ~slow_q;
		end else if (i_mem_req) begin
			if (wait_q >= {slow_q, 1'b0})
				o_mem_ack <= 1'b1;
			else
				wait_q <= wait_q + 2'h1;
		end
	end
	// Table word is the handler address; garbage off the answer
	assign o_mem_rdata = o_mem_ack ? HND_OFS + i_mem_addr
		: ~(HND_OFS + i_mem_addr);
	// Vector only during the S_EXT step; inverted otherwise
	assign o_low_data_pins = (i_mem_req && i_mem_op == S_EXT)
		? {1'b0, EXT_VEC} : {1'b1, ~EXT_VEC};
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt arbiter.
// Assumes the arbiter and the memory responder model.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import irq_arb_pkg::*;
	localparam logic [31:0] VBASE = 32'h0000_2000;
	localparam logic [31:0] HND   = 32'h0001_0000;
	localparam logic [6:0]  NMIV  = 7'h0b;  // Arbitrary value
	localparam logic [6:0]  EXTV  = 7'h55;
	logic clk, rst, nmi, dec, ack, irq, accept, mreq, mload;
	logic [3:0]       pins, mask, preq, nmask, mask_seen;
	logic [3:0][3:0]  plev;
	logic [3:0][6:0]  pvec;
	logic [4:0]       lvl;
	logic [7:0]       ldp;
	logic [31:0]      rdat, maddr, d, vaddr_seen, hnd_seen;
	logic [1:0]       r;
	seq_state_t       mop;
	axil_req_t        rq;
	axil_rsp_t        rs;
	int               mismatches;
	int               total_checks;
	logic [3:0]       lvl_tab [3] = '{4'hf, 4'he, 4'h1};
	logic [6:0]       vec_tab [3] = '{7'h47, 7'h47, 7'h40};
	irq_arbiter #(.NPER(4), .NMI_VEC(NMIV)) irq_arbiter_i (
		.i_clk_sys(clk), .i_rst(rst), .i_axil(rq), .o_axil(rs),
		.i_nmi_pin(nmi), .i_level_request_pins(pins),
		.i_periph_req(preq), .i_periph_level(plev),
		.i_periph_vec(pvec), .i_cpu_mask_level(mask),
		.i_vector_base(VBASE), .i_decode(dec), .i_mem_ack(ack),
		.i_mem_rdata(rdat), .i_low_data_pins(ldp), .o_irq_req(irq),
		.o_irq_level(lvl), .o_accept(accept), .o_mem_req(mreq),
		.o_mem_op(mop), .o_mem_addr(maddr), .o_mask_load(mload),
		.o_new_mask(nmask));
	cpu_mem_model #(.EXT_VEC(EXTV), .HND_OFS(HND)) cpu_mem_model_i (
		.i_clk_sys(clk), .i_rst(rst), .i_mem_req(mreq),
		.i_mem_op(mop), .i_mem_addr(maddr), .o_mem_ack(ack),
		.o_mem_rdata(rdat), .o_low_data_pins(ldp));
	// ------------------------------------------------------------
	// Clock, watchdog, entry monitor
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test;
	end
	always @(posedge clk) begin
		if (mreq && ack && mop == S_VEC)
			vaddr_seen <= maddr;
		if (mreq && ack && mop == S_FETCH)
			hnd_seen <= maddr;
		if (mload)
			mask_seen <= nmask;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] e);
		total_checks++;
		if (seen !== e) begin
			mismatches++;
			$display("[FAIL] %0t: seen %h, expected %h", $time, seen, e);
		end
	endtask
	task automatic chk1(input logic seen, input logic e);
		check({31'h0, seen}, {31'h0, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		rq.awvalid <= 1'b1;
		rq.awaddr  <= a;
		rq.wvalid  <= 1'b1;
		rq.wdata   <= v;
		rq.wstrb   <= 4'hf;
		rq.bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (rq.awvalid && rs.awready)
				rq.awvalid <= 1'b0;
			if (rq.wvalid && rs.wready)
				rq.wvalid <= 1'b0;
			if (rs.bvalid)
				break;
		end
		r = rs.bresp;
		rq.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		rq.arvalid <= 1'b1;
		rq.araddr  <= a;
		rq.rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (rq.arvalid && rs.arready)
				rq.arvalid <= 1'b0;
			if (rs.rvalid)
				break;
		end
		d = rs.rdata;
		r = rs.rresp;
		rq.rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		check(d, e);
	endtask
	// Decode strobe, run the entry, then load the mask as the CPU
	task automatic take(input logic [6:0] vec, input logic [3:0] lv);
		@(posedge clk) dec <= 1'b1;
		#1 chk1(accept, 1'b1);
		@(posedge clk) dec <= 1'b0;
		@(posedge clk) dec <= 1'b1;
		#1 chk1(accept, 1'b0);
		@(posedge clk) dec <= 1'b0;
		while (mreq === 1'b1)
			@(posedge clk);
		#1;
		check(vaddr_seen, VBASE + {vec, 2'b00});
		check(hnd_seen, HND + VBASE + {vec, 2'b00});
		check({28'h0, mask_seen}, {28'h0, lv});
		@(posedge clk) mask <= lv;
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		nmi = 1'b0;
		dec = 1'b0;
		pins = 4'h0;
		mask = 4'h0;
		preq = 4'h0;
		rq = '0;
		plev = {4'h3, 4'h7, 4'h7, 4'h5};
		pvec = {7'h23, 7'h22, 7'h21, 7'h20};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk(CTRL_OFS, 32'h0);
		@(posedge clk) nmi <= 1'b1;
		rdchk(CTRL_OFS, 32'h8000);
		wr(CTRL_OFS, 32'hffff_ffff);
		rdchk(CTRL_OFS, 32'h8101);
		wr(CTRL_OFS, 32'h0);
		rd(8'h10);
		check(d, 32'h0);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h10, 32'h0);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test registers done");
		@(posedge clk) begin
			mask <= 4'hf;
			nmi <= 1'b0;
		end
		tick(2);
		chk1(irq, 1'b1);
		check({27'h0, lvl}, {27'h0, NMI_LEVEL});
		rdchk(STAT_OFS, 32'h70);
		take(NMIV, 4'hf);
		tick(1);
		chk1(irq, 1'b0);
		wr(CTRL_OFS, 32'h100);
		check({30'h0, r}, {30'h0, RESP_OKAY});
		@(posedge clk) nmi <= 1'b1;
		tick(2);
		chk1(irq, 1'b1);
		take(NMIV, 4'hf);
		@(posedge clk) nmi <= 1'b0;
		tick(3);
		chk1(irq, 1'b0);
		wr(CTRL_OFS, 32'h0);
		$display("test nmi done");
		@(posedge clk) begin
			mask <= 4'h3;
			preq <= 4'b0001;
		end
		tick(1);
		chk1(irq, 1'b0);
		tick(1);
		chk1(irq, 1'b1);
		check({27'h0, lvl}, 32'd5);
		@(posedge clk) preq <= 4'b0111;
		tick(2);
		check({27'h0, lvl}, 32'd7);
		take(7'h21, 4'h7);
		@(posedge clk) preq <= 4'b0101;
		tick(3);
		chk1(irq, 1'b0);
		@(posedge clk) mask <= 4'h3;
		tick(3);
		chk1(irq, 1'b1);
		@(posedge clk) preq <= 4'b0000;
		tick(1);
		chk1(irq, 1'b1);
		tick(1);
		chk1(irq, 1'b0);
		rdchk(STAT_OFS, 32'h2100);
		$display("test periph done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) begin
				mask <= 4'h0;
				pins <= lvl_tab[i];
			end
			tick(4);
			chk1(irq, 1'b0);
			tick(1);
			chk1(irq, 1'b1);
			take(vec_tab[i], lvl_tab[i]);
			@(posedge clk) pins <= 4'h0;
			tick(8);
		end
		@(posedge clk) pins <= 4'h6;
		@(posedge clk);
		@(posedge clk) pins <= 4'h0;
		repeat (6) begin
			tick(1);
			chk1(irq, 1'b0);
		end
		$display("test levels done");
		wr(CTRL_OFS, 32'h1);
		@(posedge clk) begin
			mask <= 4'h0;
			pins <= 4'h9;
		end
		tick(5);
		chk1(irq, 1'b1);
		take(EXTV, 4'h9);
		@(posedge clk) pins <= 4'h0;
		$display("test extvec done");
		end_of_test;
	end
endmodule
`default_nettype wire
